/* verilog/tcm_mode_output_policy.sv */
// Register access over Avalon-MM and the placing of the registers are this design's own decisions.
`timescale 1ns/100ps
`default_nettype none
module tcm_mode_output_policy (
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             srst,
  // Avalon-MM slave
  input  wire logic [5:0]       avs_address,
  input  wire logic             avs_read,
  input  wire logic             avs_write,
  input  wire logic [31:0]      avs_writedata,
  input  wire logic [3:0]       avs_byteenable,
  output var  logic [31:0]      avs_readdata,
  output var  logic             avs_waitrequest,
  // Transistor outputs
  output var  tcm_pkg::tcm_out_s tr_out
);
  import tcm_pkg::*;

  tcm_bus_e       bus_q;
  logic [31:0]    rdata_q;
  logic [2:0]     cfg_mode_q;
  logic           cfg_clear_q;
  logic [3:0]     cfg_dir_q;
  tcm_mode_e      act_mode_q;
  logic           act_clear_q;
  logic [3:0]     act_dir_q;
  logic [2:0]     host_q;
  logic           cont_q;
  logic [7:0]     stopm_q;
  logic [7:0]     dem_q;
  logic           err_q;
  tcm_out_s       out_q;
  tcm_out_s       out_d;
  tcm_role_e      role [NCH];
  logic [3:0]     meas_only;
  logic           halt;
  logic           wr_go;
  logic           rd_go;
  logic [31:0]    wmask;
  logic [31:0]    wval;
  logic [31:0]    rd_mux;
  logic           normal_mode;
  logic           flag_area;
  logic [2:0]     hc_loops;
  logic [2:0]     std_loops;
  logic           ch2_vis;
  logic           ch34_vis;

  assign avs_readdata    = rdata_q;
  assign avs_waitrequest = bus_q[0]; // Idle code has bit 0 set
  assign tr_out          = out_q;

  // Bus handshake: first edge latches read data, second edge completes
  assign wr_go = avs_write && (bus_q == BUS_ACK);
  assign rd_go = avs_read && (bus_q == BUS_IDLE);

  always_comb
  begin
    for (int b = 0; b < 4; b++)
    begin
      wmask[8*b +: 8] = {8{avs_byteenable[b]}};
    end
  end

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      bus_q <= BUS_IDLE;
    end
    else
    begin
      case (bus_q)
        BUS_IDLE: if (avs_read || avs_write) bus_q <= BUS_ACK;
        BUS_ACK:  bus_q <= BUS_IDLE;
        default:  bus_q <= BUS_IDLE;
      endcase
    end
  end

  // Channel roles per mode
  generate
    for (genvar i = 0; i < NCH; i++)
    begin : g_role
      always_comb
      begin
        role[i] = ROLE_STD;
        case (act_mode_q)
          MODE_STD:      role[i] = ROLE_STD;
          MODE_HC_NORM:  role[i] = (i < 2) ? ROLE_HC : ROLE_MEAS;
          MODE_HC_EXP:   role[i] = ROLE_HC;
          MODE_MIX_NORM: role[i] = (i == 0) ? ROLE_HC : ((i == 1) ? ROLE_MEAS : ROLE_STD);
          MODE_MIX_EXP:  role[i] = (i < 2) ? ROLE_HC : ROLE_STD;
          default:       role[i] = ROLE_STD;
        endcase
      end

      always_comb
      begin
        out_d.heat[i] = 1'b0;
        out_d.cool[i] = 1'b0;
        meas_only[i]  = (role[i] == ROLE_MEAS);
        if (!halt)
        begin
          case (role[i])
            // Reverse action heats below target, forward action drives the heat output above it
            ROLE_STD: out_d.heat[i] = act_dir_q[i] ? dem_q[DEM_ABOVE_LSB+i] : dem_q[i];
            ROLE_HC:
            begin
              out_d.heat[i] = dem_q[i] && !dem_q[DEM_ABOVE_LSB+i];
              out_d.cool[i] = dem_q[DEM_ABOVE_LSB+i] && !dem_q[i];
            end
            default: ;
          endcase
        end
      end
    end
  endgenerate

  // Stop modes in stopm_q do not enter halt, which comes from host_q, cont_q and act_clear_q; a halted channel drives nothing
  always_comb
  begin
    halt = 1'b0;
    if (host_q[HOST_RST_BIT])
      halt = 1'b1;
    else if (host_q[HOST_SERR_BIT] && act_clear_q)
      halt = 1'b1;
    else if (host_q[HOST_SERR_BIT] && (cont_q == CONT_STOP))
      halt = 1'b1;
    else if (!host_q[HOST_RUN_BIT] && (cont_q == CONT_STOP))
      halt = 1'b1;
  end

  always_ff @(posedge clk)
  begin
    if (srst)
      out_q <= '0;
    else
      out_q <= out_d;
  end

  assign normal_mode = (act_mode_q == MODE_HC_NORM) || (act_mode_q == MODE_MIX_NORM);
  assign flag_area   = (avs_address == OFS_CH2_FLAG) || (avs_address == OFS_CH3_FLAG) ||
                       (avs_address == OFS_CH4_FLAG);
  assign ch2_vis     = (act_mode_q == MODE_MIX_EXP);
  assign ch34_vis    = (act_mode_q == MODE_HC_EXP);

  always_comb
  begin
    hc_loops  = 3'h0;
    std_loops = 3'h0;
    for (int i = 0; i < NCH; i++)
    begin
      hc_loops  = hc_loops + 3'((role[i] == ROLE_HC) ? 1 : 0);
      std_loops = std_loops + 3'((role[i] == ROLE_STD) ? 1 : 0);
    end
  end

  // Staged configuration; write values merged under byte enables
  always_comb
  begin
    wval = avs_writedata & wmask;
  end

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      cfg_mode_q  <= RST_MODE;
      cfg_clear_q <= RST_CLEAR;
      cfg_dir_q   <= RST_DIR;
    end
    else if (wr_go && (avs_address == OFS_CFG))
    begin
      if (avs_byteenable[0])
      begin
        cfg_mode_q  <= avs_writedata[CFG_MODE_LSB +: 3];
        cfg_clear_q <= avs_writedata[CFG_CLEAR_BIT];
      end
      if (avs_byteenable[1])
        cfg_dir_q <= avs_writedata[CFG_DIR_LSB +: 4];
    end
  end

  // Load takes effect only while the host is not running, and only for legal modes
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      act_mode_q  <= MODE_STD;
      act_clear_q <= RST_CLEAR;
      act_dir_q   <= RST_DIR;
    end
    else if (wr_go && (avs_address == OFS_CFG) && avs_byteenable[2] && avs_writedata[CFG_LOAD_BIT] &&
             !host_q[HOST_RUN_BIT] && (cfg_mode_q <= MODE_MIX_EXP))
    begin
      act_mode_q  <= tcm_mode_e'(cfg_mode_q);
      act_clear_q <= cfg_clear_q;
      act_dir_q   <= cfg_dir_q;
    end
  end

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      host_q  <= RST_HOST;
      cont_q  <= CONT_STOP;
      stopm_q <= RST_STOPM;
      dem_q   <= RST_DEM;
    end
    else if (wr_go && avs_byteenable[0])
    begin
      if (avs_address == OFS_HOST)
        host_q <= avs_writedata[2:0];
      if (avs_address == OFS_CONT)
        cont_q <= avs_writedata[0];
      if (avs_address == OFS_STOPM)
        stopm_q <= avs_writedata[7:0];
      if (avs_address == OFS_DEMAND)
        dem_q <= avs_writedata[7:0];
    end
  end

  // Sticky write data error; a new error beats a clear in the same cycle
  always_ff @(posedge clk)
  begin
    if (srst)
      err_q <= 1'b0;
    else if (wr_go && flag_area && normal_mode)
      err_q <= 1'b1;
    else if (wr_go && (avs_address == OFS_STATUS) && wval[ST_ERR_BIT])
      err_q <= 1'b0;
  end

  always_comb
  begin
    rd_mux = 32'h0;
    if (avs_address == OFS_CFG)
      rd_mux = {20'h0, act_dir_q, 3'h0, cfg_clear_q, 1'b0, cfg_mode_q};
    else if (avs_address == OFS_HOST)
      rd_mux = {29'h0, host_q};
    else if (avs_address == OFS_CONT)
      rd_mux = {31'h0, cont_q};
    else if (avs_address == OFS_STOPM)
      rd_mux = {24'h0, stopm_q};
    else if (avs_address == OFS_DEMAND)
      rd_mux = {24'h0, dem_q};
    else if (avs_address == OFS_CH2_FLAG && ch2_vis)
      rd_mux = {30'h0, out_q.cool[1], out_q.heat[1]};
    else if (avs_address == OFS_CH3_FLAG && ch34_vis)
      rd_mux = {30'h0, out_q.cool[2], out_q.heat[2]};
    else if (avs_address == OFS_CH4_FLAG && ch34_vis)
      rd_mux = {30'h0, out_q.cool[3], out_q.heat[3]};
    else if (avs_address == OFS_STATUS)
      rd_mux = {8'h0, std_loops, hc_loops, halt, out_q.cool, out_q.heat, meas_only,
                act_clear_q, act_mode_q, err_q};
  end

  always_ff @(posedge clk)
  begin
    if (srst)
      rdata_q <= 32'h0;
    else if (rd_go)
      rdata_q <= rd_mux;
  end

  // Checks
  sequence s_req;
    (avs_read || avs_write) && avs_waitrequest;
  endsequence

  sequence s_done;
    !avs_waitrequest ##1 avs_waitrequest;
  endsequence

  property p_answer;
    @(posedge clk) disable iff (srst)
    s_req |-> ##1 s_done;
  endproperty
  a_answer: assert property (p_answer) else $error("bus answer not one cycle after request");

  property p_hc_norm_idle;
    @(posedge clk) disable iff (srst)
    (act_mode_q == MODE_HC_NORM) |=> (!tr_out.heat[2] && !tr_out.heat[3] && !tr_out.cool[2] && !tr_out.cool[3]);
  endproperty
  a_hc_norm_idle: assert property (p_hc_norm_idle) else $error("CH3/CH4 drive in hc normal mode");

  property p_mix_norm_idle;
    @(posedge clk) disable iff (srst)
    (act_mode_q == MODE_MIX_NORM) ##1 (act_mode_q == MODE_MIX_NORM) |-> !tr_out.heat[1] && !tr_out.cool[1];
  endproperty
  a_mix_norm_idle: assert property (p_mix_norm_idle) else $error("CH2 drives in mix normal mode");

  property p_std_single;
    @(posedge clk) disable iff (srst)
    (act_mode_q == MODE_STD) |=> (tr_out.cool == 4'h0);
  endproperty
  a_std_single: assert property (p_std_single) else $error("cooling output used in standard mode");

  property p_hc_excl;
    @(posedge clk) disable iff (srst)
    (tr_out.heat & tr_out.cool) == 4'h0;
  endproperty
  a_hc_excl: assert property (p_hc_excl) else $error("heat and cool on together");

  property p_clear_off;
    @(posedge clk) disable iff (srst)
    (host_q[HOST_SERR_BIT] && act_clear_q) |=> (tr_out == '0);
  endproperty
  a_clear_off: assert property (p_clear_off) else $error("outputs on after stop error with clear");

  property p_hold_cont;
    @(posedge clk) disable iff (srst)
    (host_q[HOST_SERR_BIT] && !host_q[HOST_RST_BIT] && !act_clear_q && cont_q == CONT_CONTINUE &&
     act_mode_q == MODE_STD && !act_dir_q[0] && dem_q[0]) |=> tr_out.heat[0];
  endproperty
  a_hold_cont: assert property (p_hold_cont) else $error("hold/continue dropped output");

  property p_reset_off;
    @(posedge clk) disable iff (srst)
    host_q[HOST_RST_BIT] |=> (tr_out == '0);
  endproperty
  a_reset_off: assert property (p_reset_off) else $error("outputs on during host reset");

  property p_flag_err;
    @(posedge clk) disable iff (srst)
    (wr_go && flag_area && normal_mode) |=> err_q ##1 err_q;
  endproperty
  a_flag_err: assert property (p_flag_err) else $error("normal mode flag write not flagged");

  property p_latch;
    @(posedge clk) disable iff (srst)
    host_q[HOST_RUN_BIT] && $past(host_q[HOST_RUN_BIT]) |-> $stable(act_mode_q) && $stable(act_clear_q);
  endproperty
  a_latch: assert property (p_latch) else $error("mode changed while running");

endmodule // tcm_mode_output_policy
`default_nettype wire

/* pkg/tcm_pkg.sv */
`default_nettype none
package tcm_pkg;

  localparam int NCH = 4;

  // Control modes selected by software
  typedef enum logic [2:0] {
    MODE_STD      = 3'h0,
    MODE_HC_NORM  = 3'h1,
    MODE_HC_EXP   = 3'h2,
    MODE_MIX_NORM = 3'h3,
    MODE_MIX_EXP  = 3'h4
  } tcm_mode_e;

  typedef enum logic [1:0] {
    ROLE_MEAS = 2'h0,
    ROLE_STD  = 2'h1,
    ROLE_HC   = 2'h2
  } tcm_role_e;

  typedef enum logic [1:0] {
    BUS_IDLE = 2'b01,
    BUS_ACK  = 2'b10
  } tcm_bus_e;

  // Per-channel stop mode codes and continuation codes
  localparam logic [1:0] STOPM_STOP    = 2'h0;
  localparam logic [1:0] STOPM_MONITOR = 2'h1;
  localparam logic [1:0] STOPM_ALERT   = 2'h2;
  localparam logic       CONT_STOP     = 1'b0;
  localparam logic       CONT_CONTINUE = 1'b1;

  // Register byte offsets
  localparam logic [5:0] OFS_CFG      = 6'h00;
  localparam logic [5:0] OFS_HOST     = 6'h04;
  localparam logic [5:0] OFS_CONT     = 6'h08;
  localparam logic [5:0] OFS_STOPM    = 6'h0c;
  localparam logic [5:0] OFS_DEMAND   = 6'h10;
  localparam logic [5:0] OFS_CH2_FLAG = 6'h14;
  localparam logic [5:0] OFS_CH3_FLAG = 6'h18;
  localparam logic [5:0] OFS_CH4_FLAG = 6'h1c;
  localparam logic [5:0] OFS_STATUS   = 6'h20;

  // Field positions
  localparam int CFG_MODE_LSB   = 0;
  localparam int CFG_CLEAR_BIT  = 4;
  localparam int CFG_DIR_LSB    = 8;
  localparam int CFG_LOAD_BIT   = 16;
  localparam int HOST_RUN_BIT   = 0;
  localparam int HOST_SERR_BIT  = 1;
  localparam int HOST_RST_BIT   = 2;
  localparam int DEM_ABOVE_LSB  = 4;
  localparam int FLAG_HEAT_BIT  = 0;
  localparam int FLAG_COOL_BIT  = 1;
  localparam int ST_ERR_BIT     = 0;

  // Reset values
  localparam logic [2:0] RST_MODE  = 3'h0;
  localparam logic       RST_CLEAR = 1'b1;
  localparam logic [3:0] RST_DIR   = 4'h0;
  localparam logic [2:0] RST_HOST  = 3'h0;
  localparam logic [7:0] RST_STOPM = 8'h00;
  localparam logic [7:0] RST_DEM   = 8'h00;

  typedef struct packed {
    logic [NCH-1:0] heat;
    logic [NCH-1:0] cool;
  } tcm_out_s;

endpackage
`default_nettype wire

/* tb/tcm_host_model.sv */
`timescale 1ns/100ps
`default_nettype none
module tcm_host_model (
  // Clock
  input  wire logic        clk,
  // Avalon-MM master side
  output var  logic [5:0]  avs_address,
  output var  logic        avs_read,
  output var  logic        avs_write,
  output var  logic [31:0] avs_writedata,
  output var  logic [3:0]  avs_byteenable,
  input  wire logic        avs_waitrequest
);
  initial
  begin
    avs_address    = 6'h00;
    avs_read       = 1'b0;
    avs_write      = 1'b0;
    avs_writedata  = 32'h0000_0000;
    avs_byteenable = 4'hf;
  end

  // Request held until waitrequest is seen low; an idle edge follows
  task automatic xfer(input logic rd, input logic [5:0] adr, input logic [31:0] wd, output logic ok);
    int n;
    n = 0;
    avs_address   <= adr;
    avs_writedata <= wd;
    avs_read      <= rd;
    avs_write     <= !rd;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (avs_waitrequest !== 1'b0 && n < 50);
    ok = (avs_waitrequest === 1'b0);
    avs_read      <= 1'b0;
    avs_write     <= 1'b0;
    // Released lines stop showing the old value
    avs_address   <= ~adr;
    avs_writedata <= ~wd;
    @(posedge clk);
  endtask
endmodule // tcm_host_model
`default_nettype wire

/* tb/tcm_mode_output_policy_tb.sv */
`timescale 1ns/100ps
`default_nettype none
module tcm_mode_output_policy_tb;
  import tcm_pkg::*;
  logic              clk;
  logic              srst;
  logic              probe;
  wire logic [5:0]   avs_address;
  wire logic         avs_read;
  wire logic         avs_write;
  wire logic [31:0]  avs_writedata;
  wire logic [3:0]   avs_byteenable;
  wire logic [31:0]  avs_readdata;
  wire logic         avs_waitrequest;
  tcm_out_s          tr_out;
  logic [31:0]       exp_q[$];
  int                n_mismatch;
  int                compares;
  localparam logic [3:0] ACT[5] = '{4'hf, 4'h3, 4'hf, 4'hd, 4'hf};
  localparam logic [3:0] HCM[5] = '{4'h0, 4'h3, 4'hf, 4'h1, 4'h3};

  tcm_host_model i_tcm_host_model (
    .clk             (clk),
    .avs_address     (avs_address),
    .avs_read        (avs_read),
    .avs_write       (avs_write),
    .avs_writedata   (avs_writedata),
    .avs_byteenable  (avs_byteenable),
    .avs_waitrequest (avs_waitrequest)
  );

  tcm_mode_output_policy i_tcm_mode_output_policy (
    .clk             (clk),
    .srst            (srst),
    .avs_address     (avs_address),
    .avs_read        (avs_read),
    .avs_write       (avs_write),
    .avs_writedata   (avs_writedata),
    .avs_byteenable  (avs_byteenable),
    .avs_readdata    (avs_readdata),
    .avs_waitrequest (avs_waitrequest),
    .tr_out          (tr_out)
  );

  initial
  begin
    clk   = 1'b0;
    srst  = 1'b1;
    probe = 1'b0;
  end
  always #10 clk = ~clk;

  task automatic end_sim();
    // Notes never matched by a result count as failures
    if (exp_q.size() != 0)
      n_mismatch++;
    $display("Mismatches %0d, comparisons %0d", n_mismatch, compares);
    if (n_mismatch == 0 && compares > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("BAD at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic bus(input logic rd, input logic [5:0] adr, input logic [31:0] d);
    logic ok;
    if (rd)
      exp_q.push_back(d);
    i_tcm_host_model.xfer(rd, adr, rd ? 32'h0 : d, ok);
    if (!ok)
    begin
      n_mismatch++;
      end_sim();
    end
  endtask

  // Expected output byte is {heat, cool}
  task automatic look(input logic [7:0] e);
    exp_q.push_back({24'h0, e});
    probe <= 1'b1;
    @(posedge clk);
    probe <= 1'b0;
  endtask

  task automatic step(input logic [31:0] cfg, input logic cont, input logic [2:0] host,
                      input logic [7:0] dem, input logic [7:0] e);
    bus(0, OFS_HOST, 32'h0);
    // Stage first: a load copies what is already staged
    bus(0, OFS_CFG, cfg);
    bus(0, OFS_CFG, cfg | (32'h1 << CFG_LOAD_BIT));
    bus(0, OFS_CONT, {31'h0, cont});
    bus(0, OFS_HOST, {29'h0, host});
    bus(0, OFS_DEMAND, {24'h0, dem});
    look(e);
  endtask

  // Result watcher: oldest note against each read answer or output probe
  always @(posedge clk)
    if ((avs_read === 1'b1 && avs_waitrequest === 1'b0) || probe)
      chk(probe ? {24'h0, tr_out} : avs_readdata, exp_q.pop_front());

  initial
  begin
    logic [7:0]  d;
    logic [3:0]  dr;
    logic [31:0] st;
    n_mismatch = 0;
    compares   = 0;
    void'($urandom(44));
    repeat (10) @(posedge clk);
    srst <= 1'b0;
    @(posedge clk);
    look(8'h00);
    bus(1, OFS_CFG, 32'h10);
    bus(1, 6'h3c, 32'h0);
    for (int m = 0; m < 5; m++)
    begin
      step({29'h0, 3'(m)}, CONT_STOP, 3'h1, 8'h0f, {ACT[m], 4'h0});
      bus(1, OFS_CH3_FLAG, (m == 2) ? 32'h1 : 32'h0);
      bus(1, OFS_CH2_FLAG, (m == 4) ? 32'h1 : 32'h0);
      if (m != 0)
      begin
        bus(0, (m < 3) ? OFS_CH3_FLAG : OFS_CH2_FLAG, 32'h3);
        look({ACT[m], 4'h0});
      end
      step({29'h0, 3'(m)}, CONT_STOP, 3'h1, 8'hf0, {4'h0, HCM[m]});
      st = {31'h0, m == 1 || m == 3} | (32'(m) << 1) | ({28'h0, ~ACT[m]} << 5) | (32'(HCM[m]) << 13)
           | (32'($countones(HCM[m])) << 18) | (32'($countones(ACT[m] & ~HCM[m])) << 21);
      bus(1, OFS_STATUS, st);
      bus(0, OFS_STATUS, 32'h1);
    end
    step(32'h10, CONT_CONTINUE, 3'h3, 8'h0f, 8'h00);
    step(32'h00, CONT_CONTINUE, 3'h3, 8'h0f, 8'hf0);
    step(32'h00, CONT_STOP, 3'h3, 8'h0f, 8'h00);
    step(32'h10, CONT_CONTINUE, 3'h0, 8'h0f, 8'hf0);
    step(32'h00, CONT_STOP, 3'h0, 8'h0f, 8'h00);
    step(32'h10, CONT_CONTINUE, 3'h5, 8'h0f, 8'h00);
    repeat (8)
    begin
      d  = 8'($urandom);
      dr = 4'($urandom);
      step({20'h0, dr, 8'h0}, CONT_STOP, 3'h1, d, {(d[3:0] & ~dr) | (d[7:4] & dr), 4'h0});
    end
    bus(0, OFS_CFG, 32'h1_0002);
    look({(d[3:0] & ~dr) | (d[7:4] & dr), 4'h0});
    bus(0, OFS_STOPM, {24'h0, d});
    bus(1, OFS_STOPM, {24'h0, d});
    // Let the watcher take the last result before the verdict
    @(posedge clk);
    end_sim();
  end
endmodule // tcm_mode_output_policy_tb
`default_nettype wire
